//--- gated_eight_bit_timer.sv
module gated_eight_bit_timer
(
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire timer_pkg::byte_write_type   count_write,
	input  wire logic                        prescale_write,
	input  wire logic [7:0]                  prescale_write_data,
	input  wire logic                        count_halt,
	input  wire logic                        count_wrap_irq_enable,
	input  wire logic                        count_wrap_flag_clear,
	input  wire timer_pkg::op_mode_type      op_mode,
	input  wire logic                        count_pin,
	output logic [7:0]                       timer_count_byte,
	output logic [7:0]                       prescale_readback,
	output logic                             count_wrap_flag,
	output logic                             count_wrap_irq
);
	import timer_pkg::*;

	prescale_cfg_type prescale_cfg;
	logic [7:0]       instr_div;
	logic [7:0]       instr_limit;
	logic             instr_tick;
	logic             pin_sync1;
	logic             pin_sync2;
	logic             pin_sync3;
	logic             pin_level;
	logic             ext_edge;
	logic             gate_open;
	logic             count_en;
	logic             psc_clear;
	logic             prescaled_tick;
	logic             wrap_now;

	// Instruction-cycle rate follows the oscillator feeding the chip
	always_comb
	begin
		case (op_mode)
			MODE_FAST: instr_limit = FAST_INSTR_CYCLES;
			MODE_SLOW: instr_limit = SLOW_INSTR_CYCLES;
			default:   instr_limit = 8'h00;
		endcase
	end

	// Divider for the instruction-cycle enable; stop mode parks it
	always_ff @(posedge core_clk)
	begin
		if (reset || instr_limit == 8'h00)
			instr_div <= 8'h00;
		else if (instr_div >= instr_limit - 8'h01)
			instr_div <= 8'h00;
		else
			instr_div <= instr_div + 8'h01;
	end

	assign instr_tick = (instr_limit != 8'h00) && (instr_div >= instr_limit - 8'h01);

	// Three-stage pin synchroniser
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			pin_sync1 <= 1'b0;
			pin_sync2 <= 1'b0;
			pin_sync3 <= 1'b0;
		end
		else
		begin
			pin_sync1 <= count_pin;
			pin_sync2 <= pin_sync1;
			pin_sync3 <= pin_sync2;
		end
	end

	// Level is taken only once per instruction cycle, so narrower pulses may be lost
	always_ff @(posedge core_clk)
	begin
		if (reset)
			pin_level <= 1'b0;
		else if (instr_tick && pin_sync2 == pin_sync3)
			pin_level <= pin_sync3;
	end

	// Edge select 0 counts rising, 1 counts falling transitions
	assign ext_edge = instr_tick && (pin_sync2 == pin_sync3) && (pin_sync3 != pin_level)
		&& (pin_sync3 != prescale_cfg.count_edge_select);

	// Capture mode gates counting on the pin level
	assign gate_open = !prescale_cfg.gate_capture_mode
		|| (pin_level != prescale_cfg.gate_level_select);

	// Halt and gate stop feeding the prescaler, so its fraction is retained
	assign count_en = !count_halt && gate_open
		&& (prescale_cfg.count_source_select ? ext_edge : instr_tick);

	assign psc_clear = prescale_write || count_write.strobe;

	tick_prescaler u_prescaler
	(
		.core_clk       (core_clk),
		.reset          (reset),
		.clear          (psc_clear),
		.count_en       (count_en),
		.ratio          (prescale_cfg.ratio),
		.prescaled_tick (prescaled_tick)
	);

	// Prescale select register
	always_ff @(posedge core_clk)
	begin
		if (reset)
			prescale_cfg <= prescale_cfg_type'(PRESCALE_RESET);
		else if (prescale_write)
			prescale_cfg <= prescale_cfg_type'(prescale_write_data);
	end

	assign prescale_readback = prescale_cfg;

	// Value register; a software load wins over a due increment
	always_ff @(posedge core_clk)
	begin
		if (reset)
			timer_count_byte <= TIMER_COUNT_RESET;
		else if (count_write.strobe)
			timer_count_byte <= count_write.data;
		else if (prescaled_tick)
			timer_count_byte <= timer_count_byte + 8'h01;
	end

	assign wrap_now = prescaled_tick && !count_write.strobe
		&& timer_count_byte == TIMER_COUNT_TOP;

	// Sticky wrap flag; a wrap in the clear cycle still sets it
	always_ff @(posedge core_clk)
	begin
		if (reset)
			count_wrap_flag <= 1'b0;
		else if (wrap_now)
			count_wrap_flag <= 1'b1;
		else if (count_wrap_flag_clear)
			count_wrap_flag <= 1'b0;
	end

	// Level request, registered from the flag and the enable; stays up until software clears the flag or the enable
	always_ff @(posedge core_clk)
	begin
		if (reset)
			count_wrap_irq <= 1'b0;
		else
			count_wrap_irq <= count_wrap_flag && count_wrap_irq_enable;
	end

	property p_load;
		@(posedge core_clk) disable iff (reset)
		count_write.strobe |=> timer_count_byte == $past(count_write.data);
	endproperty
	a_load: assert property (p_load) else $error("write did not load value");

	property p_increment;
		@(posedge core_clk) disable iff (reset)
		(prescaled_tick && !count_write.strobe)
			|=> timer_count_byte == $past(timer_count_byte) + 8'h01;
	endproperty
	a_increment: assert property (p_increment) else $error("value did not step");

	property p_wrap;
		@(posedge core_clk) disable iff (reset)
		(prescaled_tick && !count_write.strobe && timer_count_byte == 8'hff)
			|=> count_wrap_flag && timer_count_byte == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap flag missed");

	property p_irq;
		@(posedge core_clk) disable iff (reset)
		count_wrap_irq |-> $past(count_wrap_flag) && $past(count_wrap_irq_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("request without enabled flag");

	property p_halt;
		@(posedge core_clk) disable iff (reset)
		(count_halt && !count_write.strobe) |=> $stable(timer_count_byte);
	endproperty
	a_halt: assert property (p_halt) else $error("value moved while halted");

	property p_stop;
		@(posedge core_clk) disable iff (reset)
		(op_mode == MODE_STOP && !count_write.strobe)[*2] |=> $stable(timer_count_byte);
	endproperty
	a_stop: assert property (p_stop) else $error("value moved in stop mode");

	property p_gate;
		@(posedge core_clk) disable iff (reset)
		(prescale_cfg.gate_capture_mode && pin_level == prescale_cfg.gate_level_select)
			|-> !prescaled_tick;
	endproperty
	a_gate: assert property (p_gate) else $error("tick while gate closed");

	property p_source;
		@(posedge core_clk) disable iff (reset)
		(prescale_cfg.count_source_select && !ext_edge) |-> !prescaled_tick;
	endproperty
	a_source: assert property (p_source) else $error("tick without pin edge");

endmodule : gated_eight_bit_timer

//--- timer_pkg.sv
package timer_pkg;

	// Value register offset in the data plane
	localparam logic [7:0] TIMER_COUNT_OFFSET   = 8'h01;
	localparam logic [7:0] TIMER_COUNT_RESET    = 8'h00;
	localparam logic [7:0] TIMER_COUNT_TOP      = 8'hff;
	localparam logic [7:0] PRESCALE_RESET       = 8'h00;

	// Prescale select field positions
	localparam int PSC_RATIO_LSB      = 0;
	localparam int PSC_SOURCE_BIT     = 3;
	localparam int PSC_EDGE_BIT       = 4;
	localparam int PSC_CAPTURE_BIT    = 5;
	localparam int PSC_LEVEL_BIT      = 6;

	// Instruction cycle period in core clocks for the fast and slow operating modes
	localparam logic [7:0] FAST_INSTR_CYCLES = 8'h02;
	localparam logic [7:0] SLOW_INSTR_CYCLES = 8'h40;

	// Chip operating mode, gray coded along fast, slow, stop
	typedef enum logic [1:0]
	{
		MODE_FAST = 2'b00,
		MODE_SLOW = 2'b01,
		MODE_STOP = 2'b11
	} op_mode_type;

	// Prescale select register layout
	typedef struct packed
	{
		logic       reserved;
		logic       gate_level_select;
		logic       gate_capture_mode;
		logic       count_edge_select;
		logic       count_source_select;
		logic [2:0] ratio;
	} prescale_cfg_type;

	// Software write to the value register
	typedef struct packed
	{
		logic       strobe;
		logic [7:0] data;
	} byte_write_type;

endpackage : timer_pkg

//--- tick_prescaler.sv
module tick_prescaler
(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       clear,
	input  wire logic       count_en,
	input  wire logic [2:0] ratio,
	output logic            prescaled_tick
);
	import timer_pkg::*;

	logic [7:0] psc_count;
	logic [7:0] ratio_mask;

	// Ratio 2^n: mask holds the low n bits, so ratio 0 ticks on every enable
	for (genvar i = 0; i < 8; i++)
	begin : g_mask
		assign ratio_mask[i] = (ratio > 3'(i));
	end

	// A tick falls when the masked low bits are all ones
	assign prescaled_tick = count_en && !clear && ((psc_count | ~ratio_mask) == 8'hff);

	// Counter holds its value while count_en and clear are both low, so a gated pause keeps the fraction
	always_ff @(posedge core_clk)
	begin
		if (reset || clear)
			psc_count <= 8'h00;
		else if (count_en)
			psc_count <= prescaled_tick ? 8'h00 : psc_count + 8'h01;
	end

	property p_psc_clear;
		@(posedge core_clk) disable iff (reset)
		clear |=> psc_count == 8'h00;
	endproperty
	a_psc_clear: assert property (p_psc_clear) else $error("prescaler not cleared");

	property p_psc_keep;
		@(posedge core_clk) disable iff (reset)
		(!count_en && !clear) |=> $stable(psc_count);
	endproperty
	a_psc_keep: assert property (p_psc_keep) else $error("prescaler moved while idle");

endmodule : tick_prescaler

//--- pulse_source.sv
module pulse_source
(
	input  wire logic core_clk,
	output logic      count_pin
);
	timeunit 1ns;
	timeprecision 100ps;

	// Pin idles low until a scenario asks for activity
	initial count_pin = 1'b0;

	// Hold a level for n cycles; callers keep n above the sync window
	task automatic level(input logic val, input int n);
		count_pin = val;
		repeat (n) @(negedge core_clk);
	endtask : level

	// Rising edges at eight cycles per phase, always ending high
	task automatic pulses(input int n);
		repeat (n)
		begin
			level(1'b0, 8);
			level(1'b1, 8);
		end
	endtask : pulses
endmodule : pulse_source

//--- tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import timer_pkg::*;
	logic                 core_clk;
	logic                 reset;
	byte_write_type       count_write;
	logic                 prescale_write;
	logic [7:0]           prescale_write_data;
	logic                 count_halt;
	logic                 count_wrap_irq_enable;
	logic                 count_wrap_flag_clear;
	op_mode_type          op_mode;
	logic                 count_pin;
	logic [7:0]           timer_count_byte;
	logic [7:0]           prescale_readback;
	logic                 count_wrap_flag;
	logic                 count_wrap_irq;
	logic [17:0]          exp_q[$];
	logic [7:0]           v;
	int                   num_errors;
	int                   n_tests;
	event                 take;

	gated_eight_bit_timer dut
	(
		.core_clk              (core_clk),
		.reset                 (reset),
		.count_write           (count_write),
		.prescale_write        (prescale_write),
		.prescale_write_data   (prescale_write_data),
		.count_halt            (count_halt),
		.count_wrap_irq_enable (count_wrap_irq_enable),
		.count_wrap_flag_clear (count_wrap_flag_clear),
		.op_mode               (op_mode),
		.count_pin             (count_pin),
		.timer_count_byte      (timer_count_byte),
		.prescale_readback     (prescale_readback),
		.count_wrap_flag       (count_wrap_flag),
		.count_wrap_irq        (count_wrap_irq)
	);

	pulse_source src
	(
		.core_clk  (core_clk),
		.count_pin (count_pin)
	);

	// 200 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task check(input logic [17:0] seen, input logic [17:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task complete_run;
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	task cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	task wcnt(input logic [7:0] d);
		count_write = {1'b1, d};
		cyc(1);
		count_write.strobe = 1'b0;
	endtask : wcnt

	task wpsc(input logic [7:0] d);
		prescale_write = 1'b1;
		prescale_write_data = d;
		cyc(1);
		prescale_write = 1'b0;
	endtask : wpsc

	// Runs n cycles then freezes, so every snapshot is deterministic
	task run(input int n);
		count_halt = 1'b0;
		cyc(n);
		count_halt = 1'b1;
		cyc(4);
	endtask : run

	task note(input logic i, input logic f, input logic [7:0] p, input logic [7:0] c);
		exp_q.push_back({i, f, p, c});
		->take;
	endtask : note

	// Monitor pairs each snapshot with the oldest queued note
	initial
		forever
		begin
			@take;
			check({count_wrap_irq, count_wrap_flag, prescale_readback, timer_count_byte},
				exp_q.pop_front());
		end

	// Hang guard, far beyond the few thousand cycles the run needs
	initial
	begin
		#100us;
		num_errors++;
		complete_run();
	end

	initial
	begin
		{count_write, prescale_write, prescale_write_data} = '0;
		{count_wrap_irq_enable, count_wrap_flag_clear} = '0;
		count_halt = 1'b1;
		op_mode = MODE_FAST;
		reset = 1'b1;
		num_errors = 0;
		n_tests = 0;
		void'($urandom(32'h229cacd9));
		cyc(10);
		reset = 1'b0;
		cyc(1);
		note(0, 0, 8'h00, 8'h00);
		// Windows sit mid-way between increments to dodge tick phase
		for (int n = 2; n < 8; n++)
		begin
			v = 8'($urandom_range(0, 8'hf0));
			wpsc(8'(n));
			wcnt(v);
			note(0, 0, 8'(n), v);
			run(2 * ((2 << n) + (1 << (n - 1))));
			note(0, 0, 8'(n), v + 8'h02);
		end
		for (int m = 0; m < 3; m++)
		begin
			op_mode = m == 0 ? MODE_FAST : m == 1 ? MODE_SLOW : MODE_STOP;
			wpsc(8'h02);
			wcnt(8'h10);
			run(m == 0 ? 12 : 384);
			note(0, 0, 8'h02, m == 2 ? 8'h10 : 8'h11);
		end
		op_mode = MODE_FAST;
		wcnt(8'hff);
		run(12);
		note(0, 1, 8'h02, 8'h00);
		count_wrap_irq_enable = 1'b1;
		cyc(3);
		note(1, 1, 8'h02, 8'h00);
		count_wrap_flag_clear = 1'b1;
		cyc(1);
		count_wrap_flag_clear = 1'b0;
		cyc(3);
		note(0, 0, 8'h02, 8'h00);
		count_wrap_irq_enable = 1'b0;
		// Wrap run left two counts in the prescaler; a value write must drop them
		wcnt(8'h20);
		run(6);
		note(0, 0, 8'h02, 8'h20);
		// Pin counting: four rising and three falling edges
		for (int e = 0; e < 2; e++)
		begin
			wpsc(8'h08 | 8'(e << 4));
			cyc(10);
			wcnt(8'h00);
			count_halt = 1'b0;
			src.pulses(4);
			cyc(10);
			count_halt = 1'b1;
			cyc(4);
			note(0, 0, 8'h08 | 8'(e << 4), 8'(4 - e));
			src.level(1'b0, 10);
		end
		// Two short gate windows only add up to one step if kept
		for (int l = 0; l < 2; l++)
		begin
			src.level(1'(l), 10);
			wpsc(8'h23 | 8'(l << 6));
			wcnt(8'h40);
			count_halt = 1'b0;
			repeat (2)
			begin
				src.level(1'(!l), 12);
				src.level(1'(l), 30);
			end
			count_halt = 1'b1;
			cyc(4);
			note(0, 0, 8'h23 | 8'(l << 6), 8'h41);
		end
		cyc(2);
		complete_run();
	end
endmodule : tb_top
